// *** hdl/lbc_defines.svh ***
// What this block does
// (RULE1) Collision blinks in mode 2 when select bit 6 set, else mode 1.
// (RULE2) Duty inversion bit 9 swaps ON and OFF portions of every pattern.
// (RULE3) Loopback suppress bit 8 stops blinking during internal loopback.
// (RULE4) Jabber suppress bit 7, default set, stops blinking during 10 Mb/s jabber.
// (RULE5) Traffic level enable bit 5 uses mode 0 on heavy traffic, else mode 1.
// (RULE6) RX and TX active time per 1 s; heavy if either exceeds threshold times 42 ms.
// (RULE7) Mode 0 rate code sits at bits 15:12, default 0xE.
// (RULE8) Codes 0-9 give fixed long periods with small OFF percentages.
// (RULE9) Codes 10-15 give 2 to 10 Hz with 50 percent OFF.
// (RULE10) Mode 1 rate code sits at bits 11:8, default 0xC, same encoding.
// (RULE11) Mode 2 rate code is its own field, default 0x7, same encoding.
// (RULE12) Collision blinking needs that LED's collision enable and link up.
// (RULE13) Heavy decision taken at each window end; counters restart next window.
`ifndef LBC_DEFINES_SVH
`define LBC_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define LBC_IDX_COMMON   16'h40C1
`define LBC_IDX_RATE     16'h40C2
`define LBC_IDX_STATUS   16'h40C8

// ----------------------------------------
// Common control fields
// ----------------------------------------
`define LBC_COM_INVERT   9
`define LBC_COM_LPBK     8
`define LBC_COM_JABBER   7
`define LBC_COM_COLSEL   6
`define LBC_COM_LVL_EN   5
`define LBC_COM_TH_LSB   0
`define LBC_COM_TH_W     5
`define LBC_COM_RW_MASK  16'h03FF
`define LBC_COM_RESET    16'h00D2

// ----------------------------------------
// Rate control fields
// ----------------------------------------
`define LBC_RATE0_LSB    12
`define LBC_RATE1_LSB    8
`define LBC_RATE2_LSB    4
`define LBC_RATE3_LSB    0
`define LBC_RATE_RESET   16'hEC75

// ----------------------------------------
// Timing
// ----------------------------------------
`define LBC_CLK_NS       10
`define LBC_MS_NS        1000000
`define LBC_WINDOW_S     1
`define LBC_TH_UNIT_MS   42
`define LBC_MS_PER_S     1000
`define LBC_PCT_FULL     100

`endif

// *** hdl/lbc_pkg.sv ***
package lbc_pkg;
  typedef logic [3:0] lbc_rate_t;
  typedef logic [13:0] lbc_ms_t;
  typedef enum logic [1:0] {
    LBC_MODE0 = 2'b00,
    LBC_MODE1 = 2'b01,
    LBC_MODE2 = 2'b10
  } lbc_mode_t;
endpackage

// *** hdl/lbc_blink_if.sv ***
interface lbc_blink_if;
  import lbc_pkg::*;
  lbc_rate_t code;
  logic      invert;
  logic      tick;
  logic      level;
  modport gen (input code, input invert, input tick, output level);
  modport ctl (output code, output invert, output tick, input level);
endinterface

// *** hdl/lbc_blinker.sv ***
`include "lbc_defines.svh"
module lbc_blinker import lbc_pkg::*; (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic ce,
  // Pattern
  lbc_blink_if.gen  bl
);

  // ----------------------------------------
  // Rate table
  // ----------------------------------------
  function automatic lbc_ms_t period_ms(input lbc_rate_t c);
    unique case (c)
      4'h0: period_ms = 14'd10000; // RULE8
      4'h1: period_ms = 14'd9400;
      4'h2: period_ms = 14'd8000;
      4'h3: period_ms = 14'd7400;
      4'h4: period_ms = 14'd6000;
      4'h5: period_ms = 14'd4000;
      4'h6: period_ms = 14'd4000;
      4'h7: period_ms = 14'd3000;
      4'h8: period_ms = 14'd2000;
      4'h9: period_ms = 14'd1000;
      4'hA: period_ms = 14'd500; // RULE9
      4'hB: period_ms = 14'd333;
      4'hC: period_ms = 14'd250;
      4'hD: period_ms = 14'd166;
      4'hE: period_ms = 14'd125;
      4'hF: period_ms = 14'd100;
    endcase
  endfunction

  function automatic logic [6:0] off_pct(input lbc_rate_t c);
    unique case (c)
      4'h0: off_pct = 7'd6; // RULE8
      4'h1: off_pct = 7'd7;
      4'h2: off_pct = 7'd8;
      4'h3: off_pct = 7'd9;
      4'h4: off_pct = 7'd11;
      4'h5, 4'h6: off_pct = 7'd8;
      4'h7: off_pct = 7'd11;
      4'h8, 4'h9: off_pct = 7'd16;
      default: off_pct = 7'd50; // RULE9
    endcase
  endfunction

  // ----------------------------------------
  // Phase counter, off part first
  // ----------------------------------------
  lbc_ms_t     cnt_r;
  lbc_ms_t     cnt_nxt;
  logic        level_r;
  logic        level_nxt;
  lbc_ms_t     per;
  logic [20:0] off_prod;
  lbc_ms_t     off_len;

  assign bl.level = level_r;

  always_comb begin
    per       = period_ms(bl.code);
    off_prod  = 21'(per) * 21'(off_pct(bl.code));
    off_len   = 14'(off_prod / 21'(`LBC_PCT_FULL));
    cnt_nxt   = cnt_r;
    // Code change can leave cnt past the new period; wrap catches it
    if (bl.tick) begin
      cnt_nxt = (cnt_r + 14'd1 >= per) ? '0 : cnt_r + 14'd1;
    end
    level_nxt = bl.invert ? (cnt_r < off_len) : (cnt_r >= off_len); // RULE2
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r   <= '0;
      level_r <= 1'b0;
    end else if (ce) begin
      cnt_r   <= cnt_nxt;
      level_r <= level_nxt;
    end
  end

endmodule

// *** hdl/lbc_top.sv ***
// Implementation choice: register access over APB.
`include "lbc_defines.svh"
module lbc_top import lbc_pkg::*; #(
  parameter int NUM_LED     = 2,
  parameter int TICK_CYCLES = `LBC_MS_NS / `LBC_CLK_NS
) (
  // Clock, reset, enable
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire logic               ce,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [17:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // PHY state
  input  wire logic               link_up,
  input  wire logic               collision,
  input  wire logic               loopback_active,
  input  wire logic               jabber_10m,
  input  wire logic               rx_active,
  input  wire logic               tx_active,
  // Per-LED requests from the LED control registers
  input  wire logic [NUM_LED-1:0] col_blink_en,
  input  wire logic [NUM_LED-1:0] act_blink_req,
  input  wire logic [NUM_LED-1:0] led_steady,
  // LED drive and status
  output logic      [NUM_LED-1:0] led_out,
  output logic                    heavy_traffic
);

  localparam int WIN_MS = `LBC_WINDOW_S * `LBC_MS_PER_S;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [15:0] com_r;
  logic [15:0] com_nxt;
  logic [15:0] rate_r;
  logic [15:0] rate_nxt;
  logic        pready_r;
  logic        pready_nxt;
  logic        pslverr_r;
  logic        pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic [15:0] idx;
  logic        access;

  function automatic logic [15:0] read_word(input logic [15:0] i, input logic [15:0] c,
                                            input logic [15:0] r, input logic [3:0] st);
    unique case (i)
      `LBC_IDX_COMMON: read_word = c & `LBC_COM_RW_MASK;
      `LBC_IDX_RATE:   read_word = r;
      `LBC_IDX_STATUS: read_word = {12'h000, st};
      default:         read_word = 16'h0000;
    endcase
  endfunction

  function automatic logic mapped(input logic [15:0] i);
    mapped = (i == `LBC_IDX_COMMON) || (i == `LBC_IDX_RATE) || (i == `LBC_IDX_STATUS);
  endfunction

  logic [3:0] status_word;
  logic [2:0] pattern;

  assign idx     = paddr[17:2];
  assign access  = psel && penable;
  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------
  // APB: one wait state, commit on the ready edge
  // ----------------------------------------
  always_comb begin
    com_nxt     = com_r;
    rate_nxt    = rate_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    if (access && !pready_r) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !mapped(idx);
      prdata_nxt  = pwrite ? 32'h0000_0000 : {16'h0000, read_word(idx, com_r, rate_r, status_word)};
    end
    if (access && pready_r && pwrite) begin
      if (idx == `LBC_IDX_COMMON) begin
        com_nxt = pwdata[15:0] & `LBC_COM_RW_MASK;
      end
      if (idx == `LBC_IDX_RATE) begin
        rate_nxt = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      com_r     <= `LBC_COM_RESET;
      rate_r    <= `LBC_RATE_RESET;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (ce) begin
      com_r     <= com_nxt;
      rate_r    <= rate_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  logic [31:0] pre_r;
  logic [31:0] pre_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = (pre_r == 32'(TICK_CYCLES - 1));
    pre_nxt  = tick_nxt ? 32'h0000_0000 : pre_r + 32'h0000_0001;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre_r  <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (ce) begin
      pre_r  <= pre_nxt;
      tick_r <= tick_nxt;
    end
  end

  // ----------------------------------------
  // Traffic weight over one-second windows
  // ----------------------------------------
  // Activity is sampled once per ms, so bursts shorter than 1 ms may be missed
  logic [10:0] win_r;
  logic [10:0] win_nxt;
  logic [10:0] rx_ms_r;
  logic [10:0] rx_ms_nxt;
  logic [10:0] tx_ms_r;
  logic [10:0] tx_ms_nxt;
  logic        heavy_r;
  logic        heavy_nxt;
  logic [10:0] limit;
  logic        win_end;

  always_comb begin
    limit     = 11'(com_r[`LBC_COM_TH_LSB +: `LBC_COM_TH_W]) * 11'(`LBC_TH_UNIT_MS); // RULE6
    win_end   = tick_r && (win_r == 11'(WIN_MS - 1));
    win_nxt   = win_r;
    rx_ms_nxt = rx_ms_r;
    tx_ms_nxt = tx_ms_r;
    heavy_nxt = heavy_r;
    if (tick_r) begin
      win_nxt   = win_end ? 11'h000 : win_r + 11'h001;
      rx_ms_nxt = rx_ms_r + 11'(rx_active); // RULE6
      tx_ms_nxt = tx_ms_r + 11'(tx_active);
    end
    if (win_end) begin
      heavy_nxt = (rx_ms_nxt > limit) || (tx_ms_nxt > limit); // RULE13
      rx_ms_nxt = 11'h000;
      tx_ms_nxt = 11'h000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      win_r   <= 11'h000;
      rx_ms_r <= 11'h000;
      tx_ms_r <= 11'h000;
      heavy_r <= 1'b0;
    end else if (ce) begin
      win_r   <= win_nxt;
      rx_ms_r <= rx_ms_nxt;
      tx_ms_r <= tx_ms_nxt;
      heavy_r <= heavy_nxt;
    end
  end

  assign heavy_traffic = heavy_r;

  // ----------------------------------------
  // Pattern generators for modes 0, 1, 2
  // ----------------------------------------
  lbc_blink_if bl0 ();
  lbc_blink_if bl1 ();
  lbc_blink_if bl2 ();

  assign bl0.code   = rate_r[`LBC_RATE0_LSB +: 4]; // RULE7
  assign bl1.code   = rate_r[`LBC_RATE1_LSB +: 4]; // RULE10
  assign bl2.code   = rate_r[`LBC_RATE2_LSB +: 4]; // RULE11
  assign bl0.invert = com_r[`LBC_COM_INVERT]; // RULE2
  assign bl1.invert = com_r[`LBC_COM_INVERT];
  assign bl2.invert = com_r[`LBC_COM_INVERT];
  assign bl0.tick   = tick_r;
  assign bl1.tick   = tick_r;
  assign bl2.tick   = tick_r;

  lbc_blinker u_blink0 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .bl      (bl0.gen)
  );

  lbc_blinker u_blink1 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .bl      (bl1.gen)
  );

  lbc_blinker u_blink2 (
    .sys_clk (sys_clk),
    .srst    (srst),
    .ce      (ce),
    .bl      (bl2.gen)
  );

  assign pattern     = {bl2.level, bl1.level, bl0.level};
  assign status_word = {pattern, heavy_r};

  // ----------------------------------------
  // Per-LED mode choice
  // ----------------------------------------
  function automatic logic pick(input lbc_mode_t m, input logic [2:0] p);
    unique case (m)
      LBC_MODE0: pick = p[0];
      LBC_MODE1: pick = p[1];
      LBC_MODE2: pick = p[2];
      default:   pick = p[1];
    endcase
  endfunction

  logic [NUM_LED-1:0] led_r;
  logic [NUM_LED-1:0] led_nxt;
  logic               suppress;
  lbc_mode_t          col_mode;
  lbc_mode_t          act_mode;

  always_comb begin
    suppress = (com_r[`LBC_COM_LPBK] && loopback_active) // RULE3
            || (com_r[`LBC_COM_JABBER] && jabber_10m); // RULE4
    col_mode = com_r[`LBC_COM_COLSEL] ? LBC_MODE2 : LBC_MODE1; // RULE1
    act_mode = (com_r[`LBC_COM_LVL_EN] && heavy_r) ? LBC_MODE0 : LBC_MODE1; // RULE5
    for (int i = 0; i < NUM_LED; i++) begin
      if (suppress) begin
        led_nxt[i] = led_steady[i];
      end else if (col_blink_en[i] && link_up && collision) begin // RULE12
        led_nxt[i] = pick(col_mode, pattern);
      end else if (act_blink_req[i]) begin
        led_nxt[i] = pick(act_mode, pattern);
      end else begin
        led_nxt[i] = led_steady[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      led_r <= '0;
    end else if (ce) begin
      led_r <= led_nxt;
    end
  end

  assign led_out = led_r;

endmodule

// *** test/lbc_monitor.sv ***
`include "lbc_defines.svh"
module lbc_monitor import lbc_pkg::*; #(
  parameter int NUM_LED     = 2,
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               srst,
  input wire logic               ce,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [17:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // PHY state and LEDs
  input wire logic               link_up,
  input wire logic               collision,
  input wire logic               loopback_active,
  input wire logic               jabber_10m,
  input wire logic [NUM_LED-1:0] act_blink_req,
  input wire logic [NUM_LED-1:0] led_steady,
  input wire logic [NUM_LED-1:0] led_out,
  input wire logic               heavy_traffic
);
  localparam int WIN = 1000 * TICK_CYCLES;
  logic [15:0] com_r, com_nxt;
  logic        hq_r, hq_nxt;
  int unsigned gap_r, gap_nxt;

  // ----------------------------------------
  // Shadow of common control, window spacing
  // ----------------------------------------
  always_comb begin
    com_nxt = com_r;
    if (psel && penable && pready && pwrite && paddr[17:2] == `LBC_IDX_COMMON) begin
      com_nxt = pwdata[15:0] & 16'h03FF;
    end
    hq_nxt  = heavy_traffic;
    gap_nxt = (heavy_traffic != hq_r) ? 0 : gap_r + 1;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      com_r <= 16'h00D2;
      hq_r  <= 1'b0;
      gap_r <= 0;
    end else if (ce) begin
      com_r <= com_nxt;
      hq_r  <= hq_nxt;
      gap_r <= gap_nxt;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable)) else $error("pready without access");
  reset_quiet_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    srst |=> !pready && led_out == '0 && !heavy_traffic) else $error("outputs active in reset");
  jabber_hold_a: assert property (ce && com_r[7] && jabber_10m |=> led_out == $past(led_steady))
    else $error("blink during jabber");
  lpbk_hold_a: assert property (ce && com_r[8] && loopback_active |=> led_out == $past(led_steady))
    else $error("blink during loopback");
  idle_follow_a: assert property (ce && act_blink_req == '0 && !(collision && link_up)
    |=> led_out == $past(led_steady)) else $error("blink without cause");
  window_gap_a: assert property (heavy_traffic != hq_r |-> gap_r >= WIN - 2)
    else $error("heavy changed inside window");
endmodule

bind lbc_top lbc_monitor #(.NUM_LED(NUM_LED), .TICK_CYCLES(TICK_CYCLES)) lbc_monitor_i (
  .sys_clk(sys_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .link_up(link_up),
  .collision(collision), .loopback_active(loopback_active), .jabber_10m(jabber_10m),
  .act_blink_req(act_blink_req), .led_steady(led_steady), .led_out(led_out),
  .heavy_traffic(heavy_traffic));

// *** test/lbc_top_tb_top.sv ***
`include "lbc_defines.svh"
module lbc_top_tb_top;
  import lbc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic link_up, collision, lpbk, jab, rx, tx, heavy;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  col_en, act_req, steady, led;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int per[16] = '{10000, 9400, 8000, 7400, 6000, 4000, 4000, 3000, 2000, 1000, 500, 333, 250, 166, 125, 100};
  int pct[16] = '{6, 7, 8, 9, 11, 8, 8, 11, 16, 16, 50, 50, 50, 50, 50, 50};

  // One tick per cycle keeps all sixteen periods affordable
  lbc_top #(.NUM_LED(2), .TICK_CYCLES(1)) lbc_top_i (
    .sys_clk(sys_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_up(link_up), .collision(collision), .loopback_active(lpbk), .jabber_10m(jab),
    .rx_active(rx), .tx_active(tx), .col_blink_en(col_en), .act_blink_req(act_req),
    .led_steady(steady), .led_out(led), .heavy_traffic(heavy));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      bad_count++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task do_reset(input int n);
    srst <= 1'b1;
    {link_up, collision, lpbk, jab, rx, tx} <= 6'h00;
    {col_en, act_req, steady} <= 6'h00;
    repeat (n) @(posedge sys_clk);
    srst <= 1'b0;
  endtask

  // Holds the request until pready is seen at an edge
  task apb(input logic w, input logic [15:0] idx, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    {psel, penable, pwrite} <= {1'b1, 1'b0, w};
    paddr  <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // A transfer that never completes counts against the run
    if (n >= 50) begin
      bad_count++;
      $display("CHECK FAILED t=%0t no pready", $time);
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function int on_t(input int c, input bit inv);
    int off;
    off = per[c] * pct[c] / 100;
    return inv ? off : per[c] - off;
  endfunction

  task meas(input int p, input int exp);
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk);
    repeat (p) begin
      @(posedge sys_clk);
      n += (led[0] === 1'b1);
    end
    chk(n, exp);
  endtask

  task wait_heavy(input logic v);
    int n;
    n = 0;
    while (heavy !== v && n < 2100) begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, heavy}, {31'h0, v});
  endtask

  task t_regs;
    apb(1'b0, `LBC_IDX_COMMON, 16'h0000);
    chk(rd, 32'h0000_00D2);
    apb(1'b0, `LBC_IDX_RATE, 16'h0000);
    chk(rd, 32'h0000_EC75);
    apb(1'b1, `LBC_IDX_COMMON, 16'hFFFF);
    apb(1'b0, `LBC_IDX_COMMON, 16'h0000);
    chk(rd, 32'h0000_03FF);
    apb(1'b0, 16'h4000, 16'h0000);
    chk({31'h0, err}, 32'h1);
  endtask

  // Rising periods so the counter never sits past a new period
  task t_codes;
    apb(1'b1, `LBC_IDX_COMMON, 16'h0000);
    act_req <= 2'b11;
    for (int c = 15; c >= 0; c--) begin
      apb(1'b1, `LBC_IDX_RATE, {4'h0, 4'(c), 8'h00});
      meas(per[c], on_t(c, 1'b0));
    end
  endtask

  task t_misc;
    do_reset(2);
    apb(1'b1, `LBC_IDX_COMMON, 16'h0200);
    apb(1'b1, `LBC_IDX_RATE, 16'h0900);
    act_req <= 2'b11;
    meas(1000, on_t(9, 1'b1));
    do_reset(2);
    apb(1'b1, `LBC_IDX_COMMON, 16'h0021);
    apb(1'b1, `LBC_IDX_RATE, 16'hF900);
    act_req <= 2'b11;
    rx <= 1'b1;
    wait_heavy(1'b1);
    apb(1'b0, `LBC_IDX_STATUS, 16'h0000);
    chk(rd & 32'h0000_0001, 32'h0000_0001);
    meas(100, 50);
    apb(1'b1, `LBC_IDX_COMMON, 16'h0001);
    meas(1000, 840);
    {rx, tx} <= 2'b01;
    repeat (1100) @(posedge sys_clk);
    chk({31'h0, heavy}, 32'h1);
    tx <= 1'b0;
    wait_heavy(1'b0);
  endtask

  task t_col_supp;
    do_reset(2);
    apb(1'b1, `LBC_IDX_RATE, 16'h09F0);
    {collision, link_up, col_en} <= 4'hF;
    meas(100, 50);
    apb(1'b1, `LBC_IDX_COMMON, 16'h0000);
    meas(1000, 840);
    {link_up, steady} <= 3'b001;
    meas(100, 100);
    chk({30'h0, led}, 32'h0000_0001);
    {link_up, col_en} <= 3'b100;
    meas(100, 100);
    do_reset(2);
    apb(1'b1, `LBC_IDX_RATE, 16'h0F00);
    {act_req, jab} <= 3'b111;
    meas(100, 0);
    apb(1'b1, `LBC_IDX_COMMON, 16'h0000);
    meas(100, 50);
    {jab, lpbk} <= 2'b01;
    apb(1'b1, `LBC_IDX_COMMON, 16'h0100);
    meas(100, 0);
    apb(1'b1, `LBC_IDX_COMMON, 16'h0000);
    meas(100, 50);
  endtask

  initial begin
    {ce, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'b000, 18'h0, 32'h0};
    do_reset(10);
    t_regs();
    t_codes();
    t_misc();
    t_col_supp();
    give_verdict();
  end
endmodule
